// file: inc/servo_cmd_pkg.sv
package servo_cmd_pkg;
	// Command codes and data numbers as two-digit hex
	localparam logic [7:0]  CMD_IO_ENABLE  = 8'h90;
	localparam logic [7:0]  CMD_FORCE_IN   = 8'h92;
	localparam logic [7:0]  CMD_TEST_MODE  = 8'h8B;
	localparam logic [7:0]  CMD_TEST_DATA  = 8'hA0;
	localparam logic [7:0]  DNO_IN_OFF     = 8'h00;
	localparam logic [7:0]  DNO_IN_ON      = 8'h10;
	localparam logic [7:0]  DNO_OUT_OFF    = 8'h03;
	localparam logic [7:0]  DNO_OUT_ON     = 8'h13;
	localparam logic [7:0]  DNO_FORCE      = 8'h00;
	localparam logic [7:0]  DNO_MODE       = 8'h00;
	localparam logic [7:0]  DNO_SPEED      = 8'h10;
	localparam logic [7:0]  DNO_ACCEL      = 8'h11;
	localparam logic [7:0]  DNO_ACCEL_CLR  = 8'h12;
	localparam logic [7:0]  DNO_DISTANCE   = 8'h13;
	localparam logic [15:0] KEY_VALUE      = 16'h1EA5;
	// Test modes
	localparam logic [2:0]  MODE_NONE      = 3'h0;
	localparam logic [2:0]  MODE_JOG       = 3'h1;
	localparam logic [2:0]  MODE_POSITION  = 3'h2;
	localparam logic [2:0]  MODE_NOMOTOR   = 3'h3;
	localparam logic [2:0]  MODE_FORCE_OUT = 3'h4;
	// Forcing word bit positions
	localparam int BIT_SERVO_ON  = 0;
	localparam int BIT_FWD_LIMIT = 1;
	localparam int BIT_REV_LIMIT = 2;
	localparam int BIT_FWD_RUN   = 11;
	localparam int BIT_REV_RUN   = 12;
	localparam int BIT_STOP      = 16;
	// Mask of the three inputs that are never disabled
	localparam logic [31:0] KEEP_MASK   = 32'h00010006;
	// Bits with a device behind them
	localparam logic [31:0] USED_MASK   = 32'hEFFF1C7F;
	// Watchdog
	localparam int CLK_HZ       = 100000000;
	localparam int WDOG_MS      = 500;
	localparam int WDOG_CYCLES  = WDOG_MS * (CLK_HZ / 1000);
	// Register map (byte addresses)
	localparam logic [7:0]  ADDR_CMD     = 8'h00;
	localparam logic [7:0]  ADDR_DATA    = 8'h04;
	localparam logic [7:0]  ADDR_STATE   = 8'h08;
	localparam logic [7:0]  ADDR_FORCE   = 8'h0C;
	localparam logic [7:0]  ADDR_SPEED   = 8'h10;
	localparam logic [7:0]  ADDR_ACCEL   = 8'h14;
	localparam logic [7:0]  ADDR_DIST    = 8'h18;
	localparam logic [7:0]  ADDR_IRQ_ST  = 8'h1C;
	localparam logic [7:0]  ADDR_IRQ_MSK = 8'h20;
	// Status event bits
	localparam int EV_DONE  = 0;
	localparam int EV_KEYERR = 1;
	localparam int EV_WDOG  = 2;
	localparam int EV_W     = 3;
endpackage : servo_cmd_pkg

// file: design/input_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a change is accepted once stages two and three agree
module input_sync #(
	parameter int W = 32
) (
	input  wire logic         mclk,
	input  wire logic         reset,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// Second stage is the first one anything may look at
			always_ff @(posedge mclk) begin
				if (reset) begin
					s1_r[i] <= 1'b0;
					s2_r[i] <= 1'b0;
					s3_r[i] <= 1'b0;
					dout[i] <= 1'b0;
				end else begin
					s1_r[i] <= din[i];
					s2_r[i] <= s1_r[i];
					s3_r[i] <= s2_r[i];
					if (s2_r[i] == s3_r[i]) dout[i] <= s3_r[i];
				end
			end
		end
	endgenerate
endmodule : input_sync

// file: design/servo_test_cmd.sv
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
// Operation
// R1 - Disabled inputs read off, zero, absent
// R2 - Forced stop and limits never disabled
// R3 - Key disable command kills inputs
// R4 - Key enable command restores inputs
// R5 - Key commands gate output device group
// R6 - Forcing command loads 32-bit device word
// R7 - Low forcing bits map control inputs
// R8 - High forcing bits map program inputs
// R9 - Silent link over 0.5s stops motor
// R10 - Master keeps polling during test mode
// R11 - Master follows the entry sequence
// R12 - Mode command selects test mode
// R13 - Master follows the exit sequence
// R14 - Jog speed and time constant load
// R15 - Jog words start, reverse, stop
// R16 - Positioning distance loads on its number
// R17 - Master also switches external inputs off
// R18 - Devices hold last received forcing word
// R19 - Key commands ignored without key value
module servo_test_cmd #(
	parameter int WDOG_LIMIT = servo_cmd_pkg::WDOG_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [31:0] extInputs,
	input  wire logic [15:0] analogIn,
	input  wire logic        pulseIn,
	input  wire logic [31:0] outDevices,
	output logic      [31:0] inputDevices,
	output logic      [15:0] analogOut,
	output logic             pulseOut,
	output logic      [31:0] outputPins,
	output logic             decelStop,
	output logic             irq
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_ACK  = 3'b100
	} bus_state_t;

	// Event width shared by status and mask; must be known before they are declared
	localparam int EV_W_L = servo_cmd_pkg::EV_W;

	bus_state_t  state_r;
	bus_state_t  state_nxt;
	logic [31:0] cmdReg_r;
	logic [31:0] dataReg_r;
	logic [31:0] forceWord_r;
	logic [15:0] speed_r;
	logic [15:0] accel_r;
	logic [31:0] distance_r;
	logic [2:0]  mode_r;
	logic        inDisabled_r;
	logic        outDisabled_r;
	logic        wdogTrip_r;
	logic [31:0] wdogCnt_r;
	logic [EV_W_L-1:0] irqStat_r;
	logic [EV_W_L-1:0] irqMask_r;
	logic [31:0] extSync;
	logic [16:0] analogSync;

	// Pin inputs cross into mclk through the synchroniser; the extra
	// stage costs a cycle of latency but keeps a bouncing pin from glitching
	input_sync #(.W(32)) u_sync_dev (
		.mclk  (mclk),
		.reset (reset),
		.din   (extInputs),
		.dout  (extSync)
	);
	input_sync #(.W(17)) u_sync_ana (
		.mclk  (mclk),
		.reset (reset),
		.din   ({pulseIn, analogIn}),
		.dout  (analogSync)
	);

	// Bus decode
	wire busReq   = wb_cyc_i && wb_stb_i;
	wire wrStrobe = (state_r == ST_ACK) && wb_we_i;
	wire fullWord = (wb_sel_i == 4'hF);
	wire hitCmd   = wb_adr_i == servo_cmd_pkg::ADDR_CMD;
	wire hitData  = wb_adr_i == servo_cmd_pkg::ADDR_DATA;
	wire hitState = wb_adr_i == servo_cmd_pkg::ADDR_STATE;
	wire hitForce = wb_adr_i == servo_cmd_pkg::ADDR_FORCE;
	wire hitSpeed = wb_adr_i == servo_cmd_pkg::ADDR_SPEED;
	wire hitAccel = wb_adr_i == servo_cmd_pkg::ADDR_ACCEL;
	wire hitDist  = wb_adr_i == servo_cmd_pkg::ADDR_DIST;
	wire hitIrqSt = wb_adr_i == servo_cmd_pkg::ADDR_IRQ_ST;
	wire hitIrqMk = wb_adr_i == servo_cmd_pkg::ADDR_IRQ_MSK;

	// Writing the command register with all lanes issues one serial command
	wire        issue   = wrStrobe && hitCmd && fullWord;
	wire [7:0]  cmdCode = wb_dat_i[15:8];
	wire [7:0]  dataNo  = wb_dat_i[7:0];
	wire [31:0] arg     = dataReg_r;
	wire        keyOk   = arg[15:0] == servo_cmd_pkg::KEY_VALUE;

	wire isIo    = issue && cmdCode == servo_cmd_pkg::CMD_IO_ENABLE;
	wire isForce = issue && cmdCode == servo_cmd_pkg::CMD_FORCE_IN
		&& dataNo == servo_cmd_pkg::DNO_FORCE;
	wire isMode  = issue && cmdCode == servo_cmd_pkg::CMD_TEST_MODE
		&& dataNo == servo_cmd_pkg::DNO_MODE;
	wire isData  = issue && cmdCode == servo_cmd_pkg::CMD_TEST_DATA;
	wire inOff   = isIo && dataNo == servo_cmd_pkg::DNO_IN_OFF && keyOk;   // see R3 see R19
	wire inOn    = isIo && dataNo == servo_cmd_pkg::DNO_IN_ON && keyOk;    // see R4 see R19
	wire outOff  = isIo && dataNo == servo_cmd_pkg::DNO_OUT_OFF && keyOk;  // see R5 see R19
	wire outOn   = isIo && dataNo == servo_cmd_pkg::DNO_OUT_ON && keyOk;   // see R5 see R19
	wire accClr  = isData && dataNo == servo_cmd_pkg::DNO_ACCEL_CLR && keyOk; // see R19
	wire keyCmd  = (isIo && (dataNo == servo_cmd_pkg::DNO_IN_OFF
		|| dataNo == servo_cmd_pkg::DNO_IN_ON || dataNo == servo_cmd_pkg::DNO_OUT_OFF
		|| dataNo == servo_cmd_pkg::DNO_OUT_ON))
		|| (isData && dataNo == servo_cmd_pkg::DNO_ACCEL_CLR);
	wire keyErr  = keyCmd && !keyOk;
	wire modeOk  = arg[15:0] <= 16'h0004;
	wire testOn  = mode_r != servo_cmd_pkg::MODE_NONE;
	wire wdogHit = testOn && !wdogTrip_r && (wdogCnt_r >= WDOG_LIMIT - 1);

	// Bus state: two wait states, ack for exactly one cycle, then idle
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (busReq) state_nxt = ST_EXEC;
			ST_EXEC: state_nxt = ST_ACK;
			ST_ACK:  state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) state_r <= ST_IDLE;
		else state_r <= state_nxt;
	end

	// Read mux; unmapped addresses read zero
	wire [31:0] rdData =
		hitCmd   ? cmdReg_r :
		hitData  ? dataReg_r :
		hitState ? {24'h0, wdogTrip_r, outDisabled_r, inDisabled_r, 2'b00, mode_r} :
		hitForce ? forceWord_r :
		hitSpeed ? {16'h0, speed_r} :
		hitAccel ? {16'h0, accel_r} :
		hitDist  ? distance_r :
		hitIrqSt ? {29'h0, irqStat_r} :
		hitIrqMk ? {29'h0, irqMask_r} : 32'h0;

	always_ff @(posedge mclk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= state_nxt == ST_ACK;
			wb_dat_o <= (state_nxt == ST_ACK && !wb_we_i) ? rdData : 32'h0;
		end
	end

	// Plain registers: command echo and argument
	always_ff @(posedge mclk) begin
		if (reset) begin
			cmdReg_r  <= 32'h0;
			dataReg_r <= 32'h0;
		end else begin
			if (wrStrobe && hitCmd && fullWord) cmdReg_r <= wb_dat_i;
			if (wrStrobe && hitData && fullWord) dataReg_r <= wb_dat_i;
		end
	end

	// Device group enables and test mode
	always_ff @(posedge mclk) begin
		if (reset) begin
			inDisabled_r  <= 1'b0;
			outDisabled_r <= 1'b0;
			mode_r        <= servo_cmd_pkg::MODE_NONE;
		end else begin
			if (inOff) inDisabled_r <= 1'b1;        // see R3
			else if (inOn) inDisabled_r <= 1'b0;    // see R4
			if (outOff) outDisabled_r <= 1'b1;      // see R5
			else if (outOn) outDisabled_r <= 1'b0;  // see R5
			// Out-of-range mode codes leave the mode alone
			if (isMode && modeOk) mode_r <= arg[2:0]; // see R12
		end
	end

	// Test data; the forcing word is replaced whole, never merged
	always_ff @(posedge mclk) begin
		if (reset) begin
			forceWord_r <= 32'h0;
			speed_r     <= 16'h0;
			accel_r     <= 16'h0;
			distance_r  <= 32'h0;
		end else begin
			if (isForce) forceWord_r <= arg & servo_cmd_pkg::USED_MASK; // see R6 see R18
			if (isData && dataNo == servo_cmd_pkg::DNO_SPEED) speed_r <= arg[15:0]; // see R14
			if (accClr) accel_r <= 16'h0;
			else if (isData && dataNo == servo_cmd_pkg::DNO_ACCEL) accel_r <= arg[15:0]; // see R14
			if (isData && dataNo == servo_cmd_pkg::DNO_DISTANCE) distance_r <= arg; // see R16
		end
	end

	// Watchdog: any issued command restarts it; only counts in test mode
	// Bus reads do not count as traffic: a master must issue commands to keep it fed
	always_ff @(posedge mclk) begin
		if (reset) begin
			wdogCnt_r  <= 32'h0;
			wdogTrip_r <= 1'b0;
		end else begin
			if (issue || !testOn) wdogCnt_r <= 32'h0;
			else if (!wdogTrip_r) wdogCnt_r <= wdogCnt_r + 32'h1;
			// Trip holds until test mode is left; motor stays locked
			if (!testOn) wdogTrip_r <= 1'b0;
			else if (wdogHit) wdogTrip_r <= 1'b1; // see R9
		end
	end

	// Interrupt status: set beats a write-one clear
	wire [EV_W_L-1:0] events = {wdogHit, keyErr, issue};
	wire [EV_W_L-1:0] clrBits = (wrStrobe && hitIrqSt) ? wb_dat_i[EV_W_L-1:0] : '0;
	always_ff @(posedge mclk) begin
		if (reset) begin
			irqStat_r <= '0;
			irqMask_r <= '0;
			irq       <= 1'b0;
		end else begin
			irqStat_r <= (irqStat_r & ~clrBits) | events;
			if (wrStrobe && hitIrqMk) irqMask_r <= wb_dat_i[EV_W_L-1:0];
			irq <= |(((irqStat_r & ~clrBits) | events) & irqMask_r);
		end
	end

	// Effective devices: forced word or pin, with the three safety inputs always live
	wire [31:0] keepMask = servo_cmd_pkg::KEEP_MASK;
	wire [31:0] merged   = extSync | forceWord_r; // see R7 see R8 see R15
	wire [31:0] gated    = inDisabled_r ? ((extSync & keepMask) | (forceWord_r & ~keepMask))
		: merged; // see R1 see R2

	always_ff @(posedge mclk) begin
		if (reset) begin
			inputDevices <= 32'h0;
			analogOut    <= 16'h0;
			pulseOut     <= 1'b0;
			outputPins   <= 32'h0;
			decelStop    <= 1'b0;
		end else begin
			inputDevices <= gated & servo_cmd_pkg::USED_MASK;
			analogOut    <= inDisabled_r ? 16'h0 : analogSync[15:0]; // see R1
			pulseOut     <= inDisabled_r ? 1'b0 : analogSync[16];    // see R1
			outputPins   <= outDisabled_r ? 32'h0 : outDevices;      // see R5
			decelStop    <= wdogTrip_r || wdogHit;                   // see R9
		end
	end

	// Disable command leaves inputs disabled on the next cycle
	in_disable_a: assert property (@(posedge mclk) disable iff (reset) // see R3
		inOff |=> inDisabled_r) else $error("disable not taken");
	in_enable_a: assert property (@(posedge mclk) disable iff (reset) // see R4
		inOn |=> !inDisabled_r) else $error("enable not taken");
	out_gate_a: assert property (@(posedge mclk) disable iff (reset) // see R5
		outDisabled_r |=> outputPins == 32'h0) else $error("outputs not gated");
	out_pass_a: assert property (@(posedge mclk) disable iff (reset) // see R5
		!outDisabled_r |=> outputPins == $past(outDevices))
		else $error("outputs not passed");
	key_guard_a: assert property (@(posedge mclk) disable iff (reset) // see R19
		(isIo && !keyOk) |=> $stable(inDisabled_r) && $stable(outDisabled_r))
		else $error("keyless command acted");
	accel_clear_a: assert property (@(posedge mclk) disable iff (reset) // see R19
		accClr |=> accel_r == 16'h0) else $error("time constant not cleared");
	// Safety inputs follow the pins while the rest is disabled
	safety_keep_a: assert property (@(posedge mclk) disable iff (reset) // see R2
		inDisabled_r |=> (inputDevices & servo_cmd_pkg::KEEP_MASK) ==
		($past(extSync) & servo_cmd_pkg::KEEP_MASK)) else $error("safety input lost");
	// Other pins must not leak through while disabled; only the forced word counts
	pins_ignored_a: assert property (@(posedge mclk) disable iff (reset) // see R1
		inDisabled_r |=> (inputDevices & ~servo_cmd_pkg::KEEP_MASK) ==
		($past(forceWord_r) & ~servo_cmd_pkg::KEEP_MASK))
		else $error("pin leaked while disabled");
	analog_zero_a: assert property (@(posedge mclk) disable iff (reset) // see R1
		inDisabled_r |=> analogOut == 16'h0 && !pulseOut) else $error("analog live");
	force_load_a: assert property (@(posedge mclk) disable iff (reset) // see R18
		isForce |=> forceWord_r == ($past(arg) & servo_cmd_pkg::USED_MASK))
		else $error("forcing word not loaded");
	mode_sel_a: assert property (@(posedge mclk) disable iff (reset) // see R12
		(isMode && arg[15:0] == 16'h0001) |=> mode_r == servo_cmd_pkg::MODE_JOG)
		else $error("jog mode not selected");
	mode_keep_a: assert property (@(posedge mclk) disable iff (reset) // see R12
		(isMode && !modeOk) |=> $stable(mode_r)) else $error("bad mode code taken");
	// Stop request follows the watchdog hit on the next cycle and holds while tripped
	wdog_stop_a: assert property (@(posedge mclk) disable iff (reset) // see R9
		wdogHit |=> decelStop) else $error("watchdog stop missing");
	decel_hold_a: assert property (@(posedge mclk) disable iff (reset) // see R9
		(wdogTrip_r && testOn) |=> decelStop) else $error("stop request dropped");
	jog_speed_a: assert property (@(posedge mclk) disable iff (reset) // see R14
		(isData && dataNo == servo_cmd_pkg::DNO_SPEED) |=> speed_r == $past(arg[15:0]))
		else $error("speed not loaded");
endmodule : servo_test_cmd

// file: dv/field_io_model.sv
`timescale 1ns/1ps
// Field wiring around the drive: input pins, analog, pulse train, output states
module field_io_model (
	input  wire logic        mclk,
	output logic      [31:0] extInputs,
	output logic      [15:0] analogIn,
	output logic             pulseIn,
	output logic      [31:0] outDevices
);
	// Wires start quiet so no unknown reaches the synchronisers
	initial begin
		extInputs  = 32'h0;
		analogIn   = 16'h0;
		pulseIn    = 1'b0;
		outDevices = 32'h0;
	end

	// Pins move just after an edge, never on it
	task automatic set_pins(input logic [31:0] e, input logic [15:0] a, input logic p,
		input logic [31:0] o);
		@(posedge mclk);
		extInputs  <= e;
		analogIn   <= a;
		pulseIn    <= p;
		outDevices <= o;
	endtask : set_pins
endmodule : field_io_model

// file: dv/tb_servo_test_cmd.sv
`timescale 1ns/1ps
// Command-level bench: registers over Wishbone, pins from the field model
module tb_servo_test_cmd;
	// Short watchdog so the silent-link case stays quick
	localparam int WDOG = 200;
	logic        mclk;
	logic        reset;
	logic        wbCyc, wbStb, wbWe, wbAck, pulseIn, pulseOut, decelStop, irq;
	logic [7:0]  wbAdr;
	logic [3:0]  wbSel;
	logic [31:0] wbDatI, wbDatO, extInputs, outDevices, inputDevices, outputPins, rd;
	logic [15:0] analogIn, analogOut;
	int          mismatches = 0;
	int          nChecks = 0;
	int          cycles = 0;

	field_io_model i_field (.mclk(mclk), .extInputs(extInputs), .analogIn(analogIn),
		.pulseIn(pulseIn), .outDevices(outDevices));

	servo_test_cmd #(.WDOG_LIMIT(WDOG)) i_dut (.mclk(mclk), .reset(reset),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
		.extInputs(extInputs), .analogIn(analogIn), .pulseIn(pulseIn),
		.outDevices(outDevices), .inputDevices(inputDevices), .analogOut(analogOut),
		.pulseOut(pulseOut), .outputPins(outputPins), .decelStop(decelStop), .irq(irq));

	// Clock source
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Hang guard: the whole sequence takes about a thousand cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("TB: checks %0d mismatches %0d", nChecks, mismatches);
		if (mismatches == 0 && nChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One classic cycle; request held until ack is sampled, only the hang guard ends a wait
	task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		wbCyc  <= 1'b1;
		wbStb  <= 1'b1;
		wbWe   <= w;
		wbAdr  <= a;
		wbDatI <= d;
		do begin
			@(posedge mclk);
		end while (wbAck !== 1'b1);
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask : wb_cycle

	// Argument first, then the command word; settle time covers output latency
	task automatic cmd(input logic [7:0] c, input logic [7:0] dn, input logic [31:0] d);
		wb_cycle(1'b1, servo_cmd_pkg::ADDR_DATA, d);
		wb_cycle(1'b1, servo_cmd_pkg::ADDR_CMD, {16'h0, c, dn});
		repeat (4) @(posedge mclk);
	endtask : cmd

	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb_cycle(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask : rdchk

	// Main sequence follows the test-mode entry and exit order
	initial begin
		reset  = 1'b1;
		wbCyc  = 1'b0;
		wbStb  = 1'b0;
		wbWe   = 1'b0;
		wbAdr  = 8'h00;
		wbSel  = 4'hF;
		wbDatI = 32'h0;
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		i_field.set_pins(32'h0, 16'h1234, 1'b1, 32'hA5A5_5A5A);
		repeat (8) @(posedge mclk);
		chk({15'h0, pulseOut, analogOut}, 32'h0001_1234);
		chk(outputPins, 32'hA5A5_5A5A);
		cmd(servo_cmd_pkg::CMD_FORCE_IN, 8'h00, 32'hFFFF_FFFF);
		chk(inputDevices, servo_cmd_pkg::USED_MASK);
		cmd(servo_cmd_pkg::CMD_FORCE_IN, 8'h00, 32'h0000_0807);
		chk(inputDevices, 32'h0000_0807);
		cmd(servo_cmd_pkg::CMD_FORCE_IN, 8'h00, 32'h0000_1007);
		chk(inputDevices, 32'h0000_1007);
		cmd(servo_cmd_pkg::CMD_FORCE_IN, 8'h00, 32'h0);
		i_field.set_pins(32'hFFFF_FFFF, 16'h1234, 1'b1, 32'hA5A5_5A5A);
		repeat (8) @(posedge mclk);
		chk(inputDevices, servo_cmd_pkg::USED_MASK);
		cmd(servo_cmd_pkg::CMD_IO_ENABLE, 8'h00, 32'h1EA4);
		chk(inputDevices, servo_cmd_pkg::USED_MASK);
		rdchk(servo_cmd_pkg::ADDR_IRQ_ST, 32'h2, 32'h2);
		chk({31'h0, irq}, 32'h0);
		cmd(servo_cmd_pkg::CMD_IO_ENABLE, 8'h00, 32'h1EA5);
		chk(inputDevices, servo_cmd_pkg::KEEP_MASK);
		chk({16'h0, analogOut}, 32'h0);
		chk({31'h0, pulseOut}, 32'h0);
		rdchk(servo_cmd_pkg::ADDR_STATE, 32'h20, 32'h20);
		cmd(servo_cmd_pkg::CMD_FORCE_IN, 8'h00, 32'h0000_0807);
		chk(inputDevices, 32'h0001_0807);
		cmd(servo_cmd_pkg::CMD_IO_ENABLE, 8'h03, 32'h1EA5);
		chk(outputPins, 32'h0);
		cmd(servo_cmd_pkg::CMD_IO_ENABLE, 8'h13, 32'h1EA5);
		chk(outputPins, 32'hA5A5_5A5A);
		// Every mode code, then an out-of-range code that must be ignored
		for (logic [31:0] m = 0; m < 5; m++) begin
			cmd(servo_cmd_pkg::CMD_TEST_MODE, 8'h00, m);
			rdchk(servo_cmd_pkg::ADDR_STATE, 32'h7, m);
		end
		cmd(servo_cmd_pkg::CMD_TEST_MODE, 8'h00, 32'h5);
		rdchk(servo_cmd_pkg::ADDR_STATE, 32'h7, 32'h4);
		cmd(servo_cmd_pkg::CMD_TEST_MODE, 8'h00, 32'h1);
		cmd(servo_cmd_pkg::CMD_TEST_DATA, 8'h10, 32'h0BB8);
		cmd(servo_cmd_pkg::CMD_TEST_DATA, 8'h11, 32'h01F4);
		cmd(servo_cmd_pkg::CMD_TEST_DATA, 8'h13, 32'h2710);
		rdchk(servo_cmd_pkg::ADDR_SPEED, 32'hFFFF_FFFF, 32'h0BB8);
		rdchk(servo_cmd_pkg::ADDR_ACCEL, 32'hFFFF_FFFF, 32'h01F4);
		rdchk(servo_cmd_pkg::ADDR_DIST, 32'hFFFF_FFFF, 32'h2710);
		// Master keeps the link busy for longer than the limit; no trip may follow
		repeat (30) cmd(8'h01, 8'h80, 32'h0);
		chk({31'h0, decelStop}, 32'h0);
		rdchk(servo_cmd_pkg::ADDR_STATE, 32'h80, 32'h0);
		cmd(servo_cmd_pkg::CMD_TEST_DATA, 8'h12, 32'h1EA5);
		rdchk(servo_cmd_pkg::ADDR_ACCEL, 32'hFFFF_FFFF, 32'h0);
		// Link goes silent on purpose: no command for longer than the limit
		repeat (WDOG - 60) @(posedge mclk);
		chk({31'h0, decelStop}, 32'h0);
		repeat (100) @(posedge mclk);
		chk({31'h0, decelStop}, 32'h1);
		wb_cycle(1'b1, servo_cmd_pkg::ADDR_IRQ_MSK, 32'h4);
		repeat (3) @(posedge mclk);
		chk({31'h0, irq}, 32'h1);
		rdchk(servo_cmd_pkg::ADDR_STATE, 32'h80, 32'h80);
		cmd(servo_cmd_pkg::CMD_TEST_MODE, 8'h00, 32'h0);
		chk({31'h0, decelStop}, 32'h0);
		wb_cycle(1'b1, servo_cmd_pkg::ADDR_IRQ_ST, 32'h7);
		repeat (3) @(posedge mclk);
		chk({31'h0, irq}, 32'h0);
		cmd(servo_cmd_pkg::CMD_IO_ENABLE, 8'h10, 32'h1EA5);
		chk(inputDevices, servo_cmd_pkg::USED_MASK);
		chk({15'h0, pulseOut, analogOut}, 32'h0001_1234);
		i_field.set_pins(32'h0, 16'h1234, 1'b1, 32'hA5A5_5A5A);
		repeat (8) @(posedge mclk);
		chk(inputDevices, 32'h0000_0807);
		cmd(servo_cmd_pkg::CMD_FORCE_IN, 8'h00, 32'h0);
		chk(inputDevices, 32'h0);
		rdchk(8'h3C, 32'hFFFF_FFFF, 32'h0);
		finish_test();
	end
endmodule : tb_servo_test_cmd
